//--- rtl/timer8_pkg.sv
// Constants of the 8-bit period match timer.
// Assumes one 20 MHz clock and a plain address/strobe register port.
//
// Contract
// - Prescaled instruction clock increments the count
// - Count equal to period wraps to zero
// - Each match advances postscaler, postscaler output sets flag
// - Postscale ratio is select value plus one
// - Prescale: 00 by 1, 01 by 4, 1x by 16
// - Reset: count zero, period all ones
// - Count and period fully readable and writable
// - Timer-on bit runs or holds the count
// - Count/control writes and reset clear scalers
// - Control write leaves the count unchanged
// - Control layout: post 6-3, on 2, pre 1-0
package timer8_pkg;

   // ****************************************
   // Register port
   // ****************************************
   localparam int ADDR_W = 3;                 // Address width
   localparam int DATA_W = 8;                 // Data width
   localparam logic [2:0] REG_COUNT = 3'h0;   // Count value
   localparam logic [2:0] REG_PERIOD = 3'h1;  // Period value
   localparam logic [2:0] REG_CONTROL = 3'h2; // Timer control
   localparam logic [2:0] REG_STATUS = 3'h3;  // Sticky events, read only
   localparam logic [2:0] REG_CLEAR = 3'h4;   // Event clear, write only
   localparam logic [2:0] REG_ENABLE = 3'h5;  // Event enables

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] COUNT_RST = 8'h00;   // Count after reset
   localparam logic [7:0] PERIOD_RST = 8'hFF;  // Period after reset
   localparam logic [6:0] CONTROL_RST = 7'h00; // Control after reset
   localparam logic [7:0] READ_ZERO = 8'h00;   // Idle or unmapped read

   // ****************************************
   // Control fields
   // ****************************************
   localparam int CTRL_W = 7;   // Implemented control bits
   localparam int POST_HI = 6;  // Postscale select top
   localparam int POST_LO = 3;  // Postscale select bottom
   localparam int ON_BIT = 2;   // Timer-on bit
   localparam int PRE_HI = 1;   // Prescale select top
   localparam int PRE_LO = 0;   // Prescale select bottom
   localparam int FLAG_BIT = 0; // Match flag in status/clear/enable

   // ****************************************
   // Scalers
   // ****************************************
   localparam int INST_W = 2;                  // Oscillator quarter counter
   localparam logic [1:0] INST_LAST = 2'h3;    // Fourth oscillator cycle
   localparam int PRE_W = 4;                   // Prescale counter width
   localparam logic [3:0] PRE_LAST_1 = 4'h0;   // Divide by 1
   localparam logic [3:0] PRE_LAST_4 = 4'h3;   // Divide by 4
   localparam logic [3:0] PRE_LAST_16 = 4'hF;  // Divide by 16
   localparam int POST_W = 4;                  // Postscale counter width

endpackage : timer8_pkg

//--- rtl/prescale_divider.sv
// Instruction clock divider and timer prescaler.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module prescale_divider
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Control
   input wire logic clear,
   input wire logic run,
   input wire logic [1:0] select,
   // Output enable pulse
   output logic tick
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [INST_W-1:0] quarter; // Oscillator phase
      logic [PRE_W-1:0] pre;      // Prescale count
   } pre_state_s;

   pre_state_s s_q;  // Registered state
   pre_state_s s_d;  // Next state
   logic inst_en;    // Instruction clock enable
   logic [PRE_W-1:0] last; // Terminal prescale count

   // Instruction clock is a quarter of the oscillator
   assign inst_en = (s_q.quarter == INST_LAST);

   // Ratio decode, upper bit wins
   always_comb begin
      if (select[1]) begin
         last = PRE_LAST_16;
      end else if (select[0]) begin
         last = PRE_LAST_4;
      end else begin
         last = PRE_LAST_1;
      end
   end

   // Pulse suppressed in the cycle of a clear
   assign tick = run && inst_en && !clear && (s_q.pre == last);

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.quarter = s_q.quarter + 2'h1;  // Free running phase
      if (clear) begin
         s_d.pre = '0;
      end else if (run && inst_en) begin
         s_d.pre = (s_q.pre == last) ? '0 : s_q.pre + 4'h1;
      end
   end

   // State register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   tick_spacing_a: assert property (tick |=> !tick [*3])
      else $error("prescaler ticks closer than four cycles");
   div_one_a: assert property (
      inst_en && run && !clear && select == 2'b00 |-> tick)
      else $error("divide by one missed a tick");
   clear_pre_a: assert property (clear |=> s_q.pre == '0)
      else $error("prescaler not cleared");

endmodule : prescale_divider
`default_nettype wire

//--- rtl/period_match_timer8.sv
// Top of the 8-bit period match timer with register port.
// Assumes a master that issues one-cycle strobes, never both at once.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic NRST,
   // Register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   // Interrupt
   output logic IRQ
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] count;        // Timer count
      logic [7:0] period;       // Period value
      logic [CTRL_W-1:0] ctrl;  // Timer control
      logic [POST_W-1:0] post;  // Postscale count
      logic flag;               // Sticky match flag
      logic irq_en;             // Match interrupt enable
      logic [7:0] rdata;        // Read data
   } timer_state_s;

   timer_state_s s_q;  // Registered state
   timer_state_s s_d;  // Next state

   // ****************************************
   // Decode
   // ****************************************
   logic wr_count;   // Count write
   logic wr_period;  // Period write
   logic wr_ctrl;    // Control write
   logic wr_clear;   // Event clear write
   logic wr_enable;  // Enable write
   logic scaler_clr; // Prescaler and postscaler clear
   logic timer_on;   // Run bit
   logic [1:0] prescale_select;
   logic [POST_W-1:0] postscale_select;
   logic tick;       // Prescaled increment
   logic match;      // Count meets period on increment
   logic post_fire;  // Postscaler output

   // Write decodes, at most one strobe per cycle
   assign wr_count = WR && (ADDR == REG_COUNT);
   assign wr_period = WR && (ADDR == REG_PERIOD);
   assign wr_ctrl = WR && (ADDR == REG_CONTROL);
   assign wr_clear = WR && (ADDR == REG_CLEAR);
   assign wr_enable = WR && (ADDR == REG_ENABLE);

   // Field split of control
   assign timer_on = s_q.ctrl[ON_BIT];
   assign prescale_select = s_q.ctrl[PRE_HI:PRE_LO];
   assign postscale_select = s_q.ctrl[POST_HI:POST_LO];

   // Either write restarts both scalers
   assign scaler_clr = wr_count || wr_ctrl;

   // ****************************************
   // Prescaler
   // ****************************************
   prescale_divider u_prescale (
      .clock(CLOCK),
      .nrst(NRST),
      .clear(scaler_clr),
      .run(timer_on),
      .select(prescale_select),
      .tick(tick)
   );

   // Match only counts on a real increment
   assign match = tick && (s_q.count == s_q.period);
   // Ratio is select plus one
   assign post_fire = match && (s_q.post == postscale_select);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      // Read data idles at zero between reads
      s_d.rdata = READ_ZERO;
      // Count: software write wins over increment
      // A control write suppresses the tick, so the count holds
      if (wr_count) begin
         s_d.count = WDATA;
      end else if (match) begin
         s_d.count = COUNT_RST;
      end else if (tick) begin
         s_d.count = s_q.count + 8'h01;
      end
      // Period register
      if (wr_period) begin
         s_d.period = WDATA;
      end
      // Control, top bit not stored
      if (wr_ctrl) begin
         s_d.ctrl = WDATA[CTRL_W-1:0];
      end
      // Postscaler
      if (scaler_clr) begin
         s_d.post = '0;
      end else if (post_fire) begin
         s_d.post = '0;
      end else if (match) begin
         s_d.post = s_q.post + 4'h1;
      end
      // Interrupt enable
      if (wr_enable) begin
         s_d.irq_en = WDATA[FLAG_BIT];
      end
      // Flag: clear, then set wins
      if (wr_clear && WDATA[FLAG_BIT]) begin
         s_d.flag = 1'b0;
      end
      if (post_fire) begin
         s_d.flag = 1'b1;
      end
      // Read mux, answer next cycle
      if (RD) begin
         unique case (ADDR)
            REG_COUNT: begin
               s_d.rdata = s_q.count;
            end
            REG_PERIOD: begin
               s_d.rdata = s_q.period;
            end
            REG_CONTROL: begin
               s_d.rdata = {1'b0, s_q.ctrl};
            end
            REG_STATUS: begin
               s_d.rdata = {7'h00, s_q.flag};
            end
            REG_ENABLE: begin
               s_d.rdata = {7'h00, s_q.irq_en};
            end
            default: begin
               s_d.rdata = READ_ZERO;  // Clear and unmapped
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         s_q.count <= COUNT_RST;
         s_q.period <= PERIOD_RST;
         s_q.ctrl <= CONTROL_RST;
         // Scaler count, flag and enable start cleared
         s_q.post <= '0;
         s_q.flag <= 1'b0;
         s_q.irq_en <= 1'b0;
         s_q.rdata <= READ_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Read data straight from its flop
   assign RDATA = s_q.rdata;
   // Level request while enabled flag stands
   assign IRQ = s_q.flag && s_q.irq_en;

   // ****************************************
   // Checks
   // ****************************************
   // All checks on the one clock, idle in reset
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);

   // Reset values seen at release
   reset_values_a: assert property (
      $rose(NRST) |-> s_q.count == COUNT_RST && s_q.period == PERIOD_RST
         && s_q.ctrl == CONTROL_RST)
      else $error("bad reset values");

   // Increment below period
   count_step_a: assert property (
      tick && !match |=> s_q.count == $past(s_q.count) + 8'h01)
      else $error("count did not step by one");

   // Wrap to zero on match
   period_wrap_a: assert property (
      tick && s_q.count == s_q.period |=> s_q.count == COUNT_RST)
      else $error("count did not wrap at period");

   // Flag set by postscaler output
   flag_set_a: assert property (
      match && s_q.post == postscale_select |=> s_q.flag && s_q.post == '0)
      else $error("postscaler output lost");

   // Postscaler advances one per match
   post_step_a: assert property (
      match && s_q.post != postscale_select |=> s_q.post == $past(s_q.post) + 4'h1
         && !$rose(s_q.flag))
      else $error("postscaler ratio wrong");

   // Period reads return the stored period
   read_back_a: assert property (
      RD && ADDR == REG_PERIOD |=> RDATA == $past(s_q.period))
      else $error("period read mismatch");

   // Off means held count
   hold_off_a: assert property (
      !timer_on && !wr_count |=> $stable(s_q.count))
      else $error("count moved while off");

   // Count and control writes clear postscaler
   scaler_clear_a: assert property (
      scaler_clr |=> s_q.post == '0)
      else $error("postscaler not cleared");

   // Control write keeps the count
   ctrl_keep_a: assert property (
      wr_ctrl |=> $stable(s_q.count))
      else $error("control write changed count");

   // Top control bit reads zero
   ctrl_top_a: assert property (
      RD && ADDR == REG_CONTROL |=> RDATA[7] == 1'b0)
      else $error("control bit 7 not zero");

   // Flag stays until cleared
   flag_sticky_a: assert property (
      s_q.flag && !(wr_clear && WDATA[FLAG_BIT]) |=> s_q.flag [*1])
      else $error("flag dropped without clear");

   // Request follows flag and enable
   irq_gate_a: assert property (
      IRQ |-> s_q.flag && s_q.irq_en ##1 (s_q.flag || $past(wr_clear)))
      else $error("interrupt without cause");

   // Count load from the port
   count_load_a: assert property (
      wr_count |=> s_q.count == $past(WDATA))
      else $error("count write lost");

   // Period load from the port
   period_load_a: assert property (
      wr_period |=> s_q.period == $past(WDATA))
      else $error("period write lost");

   // Control load of the implemented bits
   ctrl_load_a: assert property (
      wr_ctrl |=> s_q.ctrl == $past(WDATA[CTRL_W-1:0]))
      else $error("control write lost");

   // Count read returns the stored count
   count_read_a: assert property (
      RD && ADDR == REG_COUNT |=> RDATA == $past(s_q.count))
      else $error("count read mismatch");

   // Read data stands one cycle only
   rdata_idle_a: assert property (
      !RD |=> RDATA == READ_ZERO)
      else $error("read data not idle");

   // Clear register and unmapped places read zero
   unmapped_read_a: assert property (
      RD && (ADDR == REG_CLEAR || ADDR > REG_ENABLE) |=> RDATA == READ_ZERO)
      else $error("unmapped read not zero");

   // Status read shows the flag
   status_read_a: assert property (
      RD && ADDR == REG_STATUS |=> RDATA == {7'h00, $past(s_q.flag)})
      else $error("status read mismatch");

   // Enable read shows the enable
   enable_read_a: assert property (
      RD && ADDR == REG_ENABLE |=> RDATA == {7'h00, $past(s_q.irq_en)})
      else $error("enable read mismatch");

   // Enable load from the port
   enable_load_a: assert property (
      wr_enable |=> s_q.irq_en == $past(WDATA[FLAG_BIT]))
      else $error("enable write lost");

   // Clear without a new event drops the flag
   flag_clear_a: assert property (
      wr_clear && WDATA[FLAG_BIT] && !post_fire |=> !s_q.flag)
      else $error("flag not cleared");

   // No increment pulse while off
   off_no_tick_a: assert property (
      !timer_on |-> !tick)
      else $error("tick while timer off");

   // Postscale count never passes its select
   post_bound_a: assert property (
      s_q.post <= postscale_select)
      else $error("postscaler beyond ratio");

   // Main scenarios
   wrap_c: cover property (match ##1 s_q.count == COUNT_RST);
   flag_c: cover property (post_fire && postscale_select == 4'hF);
   clear_race_c: cover property (post_fire && wr_clear);
   ctrl_write_c: cover property (wr_ctrl && timer_on);
   load_c: cover property (wr_count && timer_on);

endmodule : period_match_timer8
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the 8-bit period match timer.
// Assumes the register map, reset values and timing of timer8_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import timer8_pkg::*;
;
   // ****************************************
   // Signals and design
   // ****************************************
   logic CLOCK = 1'b0;                 // 20 MHz clock
   logic NRST = 1'b0;                  // Reset, active low
   logic [ADDR_W-1:0] ADDR = '0;       // Register address
   logic [DATA_W-1:0] WDATA = '0;      // Write data
   logic WR = 1'b0;                    // Write strobe
   logic RD = 1'b0;                    // Read strobe
   logic [DATA_W-1:0] RDATA;           // Read data
   logic IRQ;                          // Interrupt level
   int fail_count = 0;                 // Mismatches
   int checks_done = 0;                // Comparisons

   // Half period of 25 ns
   always #25 CLOCK = ~CLOCK;

   period_match_timer8 period_match_timer8_i (
      .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));

   // ****************************************
   // Tasks
   // ****************************************
   // Compare one value
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, seen, want);
      end
   endtask : check

   // One-cycle write
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask : wr

   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd

   // Read and compare
   task automatic rdc(input logic [2:0] a, input logic [7:0] want);
      logic [7:0] v;
      rd(a, v);
      check(v, want, "register read");
   endtask : rdc

   // Cycles between two count increments
   task automatic gap(input logic [1:0] c, output int g);
      logic [7:0] a;
      logic [7:0] b;
      int n;
      wr(REG_PERIOD, 8'hFF);
      wr(REG_COUNT, 8'h00);
      wr(REG_CONTROL, {6'h01, c});
      rd(REG_COUNT, a);
      n = 0;
      do begin
         rd(REG_COUNT, b);
         n++;
      end while (b === a && n < 100);
      a = b;
      g = 0;
      do begin
         rd(REG_COUNT, b);
         g += 2;
      end while (b === a && g < 400);
      wr(REG_CONTROL, 8'h00);
   endtask : gap

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog well beyond the expected run of some 3500 cycles
   initial begin
      repeat (30000) @(posedge CLOCK);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      logic [7:0] v;
      logic [7:0] mx;
      int g;
      int n;
      int e;
      repeat (4) @(posedge CLOCK);
      NRST <= 1'b1;
      // Reset values
      rdc(REG_COUNT, 8'h00);
      rdc(REG_PERIOD, 8'hFF);
      rdc(REG_CONTROL, 8'h00);
      rdc(REG_STATUS, 8'h00);
      $display("Test reset values done");
      // Register access, control layout, refused places
      wr(REG_PERIOD, 8'h5A);
      wr(REG_COUNT, 8'hA5);
      rdc(REG_PERIOD, 8'h5A);
      rdc(REG_COUNT, 8'hA5);
      wr(REG_CONTROL, 8'hFB);
      rdc(REG_CONTROL, 8'h7B);
      @(posedge CLOCK);
      #1 check(RDATA, 8'h00, "idle read data");
      rdc(REG_COUNT, 8'hA5);
      repeat (100) @(posedge CLOCK);
      rdc(REG_COUNT, 8'hA5);
      wr(REG_STATUS, 8'hFF);
      rdc(REG_STATUS, 8'h00);
      rdc(REG_CLEAR, 8'h00);
      rdc(3'h6, 8'h00);
      rdc(3'h7, 8'h00);
      $display("Test register access done");
      // Increment spacing for every prescale code
      for (int c = 0; c < 4; c++) begin
         gap(2'(c), g);
         e = (c == 0) ? 4 : ((c == 1) ? 16 : 64);
         check(8'(g), 8'(e), "increment spacing");
      end
      $display("Test prescale done");
      // Scaler clear by control and count writes
      wr(REG_COUNT, 8'h40);
      wr(REG_CONTROL, 8'h06);
      repeat (6) begin
         repeat (40) @(posedge CLOCK);
         wr(REG_CONTROL, 8'h06);
      end
      rdc(REG_COUNT, 8'h40);
      repeat (6) begin
         repeat (40) @(posedge CLOCK);
         wr(REG_COUNT, 8'h00);
      end
      wr(REG_CONTROL, 8'h00);
      rdc(REG_COUNT, 8'h00);
      $display("Test scaler clear done");
      // Wrap at period and every postscale code
      wr(REG_PERIOD, 8'h03);
      for (int s = 0; s < 16; s++) begin
         wr(REG_CLEAR, 8'h01);
         wr(REG_COUNT, 8'h00);
         wr(REG_CONTROL, {1'b0, 4'(s), 3'b100});
         n = 0;
         do begin
            rd(REG_STATUS, v);
            n += 2;
         end while (v[0] !== 1'b1 && n < 600);
         e = 16 * (s + 1);
         check({7'h00, n >= e - 4 && n <= e + 6}, 8'h01, "flag delay");
      end
      mx = 8'h00;
      repeat (24) begin
         rd(REG_COUNT, v);
         if (v > mx) mx = v;
      end
      check(mx, 8'h03, "highest count");
      $display("Test period and postscale done");
      // Interrupt level, stickiness and clear
      wr(REG_CONTROL, 8'h00);
      #1 check({7'h00, IRQ}, 8'h00, "masked interrupt");
      wr(REG_ENABLE, 8'h01);
      #1 check({7'h00, IRQ}, 8'h01, "enabled interrupt");
      rdc(REG_ENABLE, 8'h01);
      repeat (50) @(posedge CLOCK);
      rdc(REG_STATUS, 8'h01);
      wr(REG_CLEAR, 8'h01);
      #1 check({7'h00, IRQ}, 8'h00, "cleared interrupt");
      rdc(REG_STATUS, 8'h00);
      $display("Test interrupt done");
      // Second reset in mid-run
      wr(REG_PERIOD, 8'h33);
      wr(REG_COUNT, 8'h12);
      wr(REG_CONTROL, 8'h05);
      @(posedge CLOCK);
      NRST <= 1'b0;
      repeat (2) @(posedge CLOCK);
      NRST <= 1'b1;
      rdc(REG_COUNT, 8'h00);
      rdc(REG_PERIOD, 8'hFF);
      rdc(REG_CONTROL, 8'h00);
      rdc(REG_ENABLE, 8'h00);
      $display("Test second reset done");
      tally_and_finish();
   end

endmodule : tb_top
`default_nettype wire
